/* File: verilog/qdac_defines.svh */
`ifndef QDAC_DEFINES_SVH
`define QDAC_DEFINES_SVH

`define QDAC_FRAME_BITS   18
`define QDAC_CODE_BITS    16
`define QDAC_CH_COUNT     4
`define QDAC_ADDR_HI_POS  17
`define QDAC_ADDR_LO_POS  16
`define QDAC_CODE_ZERO    16'h0000
`define QDAC_CODE_HALF    16'h8000

`endif

/* File: verilog/qdac_pkg.sv */
package qdac_pkg;

  typedef logic [15:0] qdac_code_t;
  typedef logic [1:0]  qdac_chan_t;

  typedef enum logic [1:0] {
    QDAC_ST_IDLE  = 2'b01,
    QDAC_ST_FRAME = 2'b10
  } qdac_state_t;

endpackage

/* File: verilog/qdac_pin_sync.sv */
`timescale 1ns/1ns
// two-stage synchroniser per bit, with rise detect on the stable stage
module qdac_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] init_val,
  input  wire logic             srst,
  output logic      [WIDTH-1:0] sync_out,
  output logic      [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stab_r;
  logic [WIDTH-1:0] prev_r;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge mclk) begin
        meta_r[gi] <= async_in[gi];
        stab_r[gi] <= meta_r[gi];
        if (srst) begin
          prev_r[gi] <= init_val[gi];
        end else begin
          prev_r[gi] <= stab_r[gi];
        end
      end
      assign sync_out[gi] = stab_r[gi];
      assign rise[gi]     = stab_r[gi] & ~prev_r[gi];
    end
  endgenerate

endmodule // qdac_pin_sync

/* File: verilog/qdac_serial_load.sv */
`timescale 1ns/1ns
// Operation
// R1: 18-bit frame, address then code, MSB first
// R2: shift one bit per clock rise while selected
// R3: no shift when deselected or clock steady
// R4: only last 18 bits used at deselect
// R5: deselect edge writes code to input register
// R6: address bits pick channel one to four
// R7: low load strobe makes outputs transparent
// R8: preset with level zero forces 0000h
// R9: preset with level high forces 8000h
// R10: load strobe updates all outputs together
// R11: preset acts without serial clock
// R12: reset sets registers by level select
// R13: held preset overrides any load
`include "qdac_defines.svh"

module qdac_serial_load #(
  parameter int CH_COUNT = `QDAC_CH_COUNT
) (
  input  wire logic                                  mclk,
  input  wire logic                                  srst,
  input  wire logic                                  sclk,
  input  wire logic                                  cs_n,
  input  wire logic                                  sdi,
  input  wire logic                                  load_outputs_strobe_n,
  input  wire logic                                  preset_n,
  input  wire logic                                  preset_level,
  output logic       [CH_COUNT*`QDAC_CODE_BITS-1:0]  input_regs,
  output logic       [CH_COUNT*`QDAC_CODE_BITS-1:0]  dac_regs,
  output logic                                       frame_active
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int NPIN = 6;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_init;
  logic [NPIN-1:0] pin_s;
  logic [NPIN-1:0] pin_rise;

  assign pin_raw  = {preset_level, preset_n, load_outputs_strobe_n, sdi, cs_n, sclk};
  assign pin_init = 6'h3F;

  qdac_pin_sync #(
    .WIDTH    (NPIN)
  ) u_sync (
    .mclk     (mclk),
    .async_in (pin_raw),
    .init_val (pin_init),
    .srst     (srst),
    .sync_out (pin_s),
    .rise     (pin_rise)
  );

  logic s_cs_n;
  logic s_sdi;
  logic s_load_outputs_strobe_n_n;
  logic s_preset_n;
  logic s_level;
  logic sclk_rise;
  logic cs_rise;

  assign sclk_rise  = pin_rise[0];
  assign s_cs_n     = pin_s[1];
  assign cs_rise    = pin_rise[1];
  assign s_sdi      = pin_s[2];
  assign s_load_outputs_strobe_n_n   = pin_s[3];
  assign s_preset_n = pin_s[4];
  assign s_level    = pin_s[5];

  ////////////////////////////////////////////////////////////////////////////
  // frame state and shift register

  qdac_pkg::qdac_state_t               state_r;
  qdac_pkg::qdac_state_t               state_nxt;
  logic [`QDAC_FRAME_BITS-1:0]         shift_r;
  logic [`QDAC_FRAME_BITS-1:0]         shift_nxt;
  logic                                wr_stb;
  qdac_pkg::qdac_chan_t                wr_chan;
  qdac_pkg::qdac_code_t                wr_code;

  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    wr_stb    = 1'b0;
    case (state_r)
      qdac_pkg::QDAC_ST_IDLE: begin
        if (!s_cs_n) begin
          state_nxt = qdac_pkg::QDAC_ST_FRAME;
        end
      end
      qdac_pkg::QDAC_ST_FRAME: begin
        // R2: shift on sclk rise
        // R3: held otherwise
        if (!s_cs_n && sclk_rise) begin
          // R1: msb first
          // R4: keep last bits
          shift_nxt = {shift_r[`QDAC_FRAME_BITS-2:0], s_sdi};
        end
        if (cs_rise) begin
          // R5: write strobe at deselect
          wr_stb    = 1'b1;
          state_nxt = qdac_pkg::QDAC_ST_IDLE;
        end
      end
      default: begin
        state_nxt = qdac_pkg::QDAC_ST_IDLE;
      end
    endcase
  end

  // R6: address decode
  assign wr_chan = {shift_r[`QDAC_ADDR_HI_POS], shift_r[`QDAC_ADDR_LO_POS]};
  assign wr_code = shift_r[`QDAC_CODE_BITS-1:0];

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= qdac_pkg::QDAC_ST_IDLE;
      shift_r <= '0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input and output registers

  logic                                 init_r;
  logic                                 init_nxt;
  logic                                 frame_active_nxt;
  logic [CH_COUNT*`QDAC_CODE_BITS-1:0]  in_nxt;
  logic [CH_COUNT*`QDAC_CODE_BITS-1:0]  dac_nxt;
  qdac_pkg::qdac_code_t                 preset_code;
  logic                                 force_preset;

  // R8: zero code
  // R9: half-scale code
  assign preset_code  = s_level ? `QDAC_CODE_HALF : `QDAC_CODE_ZERO;
  // R11: level-driven, no sclk needed
  // R12: first cycle after reset presets
  assign force_preset = !s_preset_n || init_r;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel next values

  genvar ci;
  generate
    for (ci = 0; ci < CH_COUNT; ci++) begin : g_ch
      qdac_pkg::qdac_code_t  ch_in_cur;
      qdac_pkg::qdac_code_t  ch_dac_cur;
      qdac_pkg::qdac_code_t  ch_in_nxt;
      qdac_pkg::qdac_code_t  ch_dac_nxt;
      logic                  ch_hit;

      assign ch_in_cur  = input_regs[ci*`QDAC_CODE_BITS +: `QDAC_CODE_BITS];
      assign ch_dac_cur = dac_regs[ci*`QDAC_CODE_BITS +: `QDAC_CODE_BITS];
      // R5: selected channel only
      assign ch_hit     = wr_stb && (int'(wr_chan) == ci);

      always_comb begin
        ch_in_nxt  = ch_in_cur;
        ch_dac_nxt = ch_dac_cur;
        // R13: preset wins
        if (force_preset) begin
          ch_in_nxt  = preset_code;
          ch_dac_nxt = preset_code;
        end else begin
          if (ch_hit) begin
            ch_in_nxt = wr_code;
          end
          // R7: transparent while strobe low
          // R10: all channels at once
          if (!s_load_outputs_strobe_n_n) begin
            ch_dac_nxt = ch_in_cur;
          end
        end
      end

      assign in_nxt[ci*`QDAC_CODE_BITS +: `QDAC_CODE_BITS]  = ch_in_nxt;
      assign dac_nxt[ci*`QDAC_CODE_BITS +: `QDAC_CODE_BITS] = ch_dac_nxt;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register stage

  // init lasts one cycle after reset
  always_comb begin
    init_nxt         = 1'b0;
    frame_active_nxt = (state_nxt == qdac_pkg::QDAC_ST_FRAME);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      init_r       <= 1'b1;
      input_regs   <= '0;
      dac_regs     <= '0;
      frame_active <= 1'b0;
    end else begin
      init_r       <= init_nxt;
      input_regs   <= in_nxt;
      dac_regs     <= dac_nxt;
      frame_active <= frame_active_nxt;
    end
  end

endmodule // qdac_serial_load

/* File: dv/qdac_host_model.sv */
`timescale 1ns/1ns
module qdac_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic send(input logic [19:0] w, input int n);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = w[i];
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    sdi = ~sdi;
    #120;
  endtask
endmodule // qdac_host_model

/* File: dv/qdac_serial_load_assertions.sv */
`timescale 1ns/1ns
module qdac_serial_load_assertions #(
  parameter int CH_COUNT = 4
) (
  input wire logic                    mclk,
  input wire logic                    srst,
  input wire logic                    cs_n,
  input wire logic                    load_outputs_strobe_n,
  input wire logic                    preset_n,
  input wire logic                    preset_level,
  input wire logic                    frame_active,
  input wire logic [CH_COUNT*16-1:0]  input_regs,
  input wire logic [CH_COUNT*16-1:0]  dac_regs
);
  localparam logic [CH_COUNT*16-1:0] H = {CH_COUNT{16'h8000}};
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  property p_zero; (!preset_n && !preset_level)[*6] |-> !(input_regs | dac_regs); endproperty
  property p_half; (!preset_n && preset_level)[*6] |-> input_regs == H && dac_regs == H; endproperty
  property p_in; (cs_n && preset_n)[*6] |=> $stable(input_regs); endproperty
  property p_out; (load_outputs_strobe_n && preset_n)[*6] |=> $stable(dac_regs); endproperty
  property p_fol; (!load_outputs_strobe_n && preset_n)[*6] |-> dac_regs == $past(input_regs); endproperty
  property p_act; !cs_n[*5] |-> frame_active; endproperty
  property p_idle; cs_n[*6] |-> !frame_active; endproperty
  property p_init;
    $fell(srst) |-> ##2 (dac_regs == (preset_level ? H : '0)) && (input_regs == (preset_level ? H : '0));
  endproperty
  a_zero: assert property (p_zero) else $error("zero preset");
  a_half: assert property (p_half) else $error("half preset");
  a_in: assert property (p_in) else $error("input moved");
  a_out: assert property (p_out) else $error("output moved");
  a_fol: assert property (p_fol) else $error("no follow");
  a_act: assert property (p_act) else $error("no frame");
  a_idle: assert property (p_idle) else $error("stuck frame");
  a_init: assert property (p_init) else $error("bad init");
endmodule // qdac_serial_load_assertions
bind qdac_serial_load qdac_serial_load_assertions #(.CH_COUNT(CH_COUNT)) i_chk (
  .mclk                  (mclk),
  .srst                  (srst),
  .cs_n                  (cs_n),
  .load_outputs_strobe_n (load_outputs_strobe_n),
  .preset_n              (preset_n),
  .preset_level          (preset_level),
  .frame_active          (frame_active),
  .input_regs            (input_regs),
  .dac_regs              (dac_regs)
);

/* File: dv/qdac_serial_load_tb.sv */
`timescale 1ns/1ns
module qdac_serial_load_tb;
  logic mclk = 1'b0, srst = 1'b1, ld_n = 1'b1, pre_n = 1'b1, lvl = 1'b0;
  logic sclk, cs_n, sdi, fa;
  logic [63:0] ir, dr, e;
  int mismatches = 0, cmp_count = 0;
  always #4 mclk = ~mclk;
  qdac_host_model i_host (.sclk, .cs_n, .sdi);
  qdac_serial_load i_dut (.mclk, .srst, .sclk, .cs_n, .sdi, .load_outputs_strobe_n(ld_n),
    .preset_n(pre_n), .preset_level(lvl), .input_regs(ir), .dac_regs(dr), .frame_active(fa));
  task automatic wt(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(logic [63:0] g, x);
    cmp_count++;
    if (g !== x) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic chk_flag(logic g, x);
    cmp_count++;
    if (g !== x) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task complete_run;
    $display("cmp %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task t_write;
    e = '0;
    for (int c = 3; c >= 0; c--) begin
      e[c*16+:16] = 16'hA5C0 ^ 16'(c);
      i_host.send({2'b0, 2'(c), e[c*16+:16]}, 18);
      wt(8);
      chk(ir, e);
    end
    chk(dr, '0);
    ld_n = 1'b0;
    wt(8);
    chk(dr, e);
    ld_n = 1'b1;
    $display("write done");
  endtask
  task t_long;
    e[47:32] = 16'h1234;
    fork
      i_host.send({4'hE, 16'h1234}, 20);
      begin
        wt(12);
        chk_flag(fa, 1'b1);
      end
    join
    wt(8);
    chk(ir, e);
    chk_flag(fa, 1'b0);
    $display("long done");
  endtask
  task t_preset;
    lvl = 1'b1;
    pre_n = 1'b0;
    i_host.send(20'h3ABCD, 18);
    wt(1);
    chk(ir, {4{16'h8000}});
    chk(dr, {4{16'h8000}});
    lvl = 1'b0;
    wt(8);
    chk(ir | dr, '0);
    pre_n = 1'b1;
    wt(8);
    $display("preset done");
  endtask
  task t_reset;
    lvl = 1'b1;
    srst = 1'b1;
    wt(16);
    srst = 1'b0;
    wt(2);
    chk(ir, {4{16'h8000}});
    chk(dr, {4{16'h8000}});
    wt(8);
    chk(ir, {4{16'h8000}});
    chk(dr, {4{16'h8000}});
    $display("reset done");
  endtask
  initial begin
    wt(16);
    srst = 1'b0;
    wt(8);
    chk(ir | dr, '0);
    t_write;
    t_long;
    t_preset;
    t_reset;
    complete_run;
  end
  initial begin
    #100000;
    mismatches++;
    complete_run;
  end
endmodule // qdac_serial_load_tb
